//--- rtl/dac_link_pkg.sv
// Shared constants and types of the serial converter write link.
// Assumes one 250 MHz system clock on both ends of the link.
package dac_link_pkg;

    // Frame layout
    localparam int FRAME_W      = 24;
    localparam int DATA_W       = 16;
    localparam int MODE_W       = 2;
    localparam int FRAME_BIT_TOP      = 23;
    localparam int MODE_BIT_HI  = 17;
    localparam int MODE_BIT_LO  = 16;
    localparam int CNT_W        = 5;
    localparam int SWRST_TOP_W  = 8;

    // Reset values and special frames
    localparam logic [15:0] MIDSCALE_CODE = 16'h8000;
    localparam logic [23:0] SWRST_FRAME   = 24'hFFFFFF;
    localparam logic [7:0]  SWRST_TOP     = 8'hFF;

    typedef enum logic [1:0] {
        MODE_NORMAL  = 2'h0,
        MODE_HIZ     = 2'h1,
        MODE_PD_100K = 2'h2,
        MODE_PD_1K   = 2'h3
    } pwr_mode_t;

    // Timing
    localparam int CLK_MHZ          = 250;
    localparam int CLK_PERIOD_NS    = 4;
    localparam int SCLK_MAX_MHZ     = 30;
    localparam int SYNC_HIGH_MIN_NS = 12;
    localparam int SYNC_HIGH_CYC    =
        (SYNC_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_HALF_CYC    =
        (CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);

    // Controller registers on APB
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  REG_FRAME   = 8'h00;
    localparam logic [7:0]  REG_WORD    = 8'h04;
    localparam logic [7:0]  REG_CTRL    = 8'h08;
    localparam logic [7:0]  REG_STATUS  = 8'h0C;
    localparam int          CTRL_LEN_LSB  = 0;
    localparam int          CTRL_IDLE_BIT = 8;
    localparam logic [4:0]  CTRL_LEN_RST  = 5'h18;
    localparam logic        CTRL_IDLE_RST = 1'h0;
    localparam int          STAT_BUSY   = 0;
    localparam int          STAT_FULL   = 1;
    localparam int          STAT_EMPTY  = 2;
    localparam int          STAT_SYNC   = 3;

endpackage : dac_link_pkg

//--- rtl/dac_link_if.sv
// Three-wire write link between the controller and the converter port.
// Assumes both ends and the bench share only these wires, the system clock and the reset.
interface dac_link_if;
    logic sync_n;
    logic sclk;
    logic din;

    modport dev (
        input sync_n,
        input sclk,
        input din
    );

    modport ctl (
        output sync_n,
        output sclk,
        output din
    );
endinterface : dac_link_if

//--- rtl/dac_serial_write_port.sv
// Serial write port of a 16-bit converter: frame capture and mode decode.
// Assumes the link pins are asynchronous to sys_clk_in and at least
// three clock periods wide per serial clock phase.
//
// Function
// - Select low opens frame, enables shifting
// - Shift one bit per falling clock edge
// - Host presents data valid at falling edge
// - Host keeps serial clock at most 30 MHz
// - 24th falling edge executes the command
// - Host may idle select low after frame
// - Host holds select high 12 ns first
// - Two mode bits, sixteen data bits
// - Data bits replace converter code
// - Early select rise discards the frame
// - Power-up loads midscale until valid frame
// - All-ones frame performs software reset
// - Started software reset survives early abort
// - Mode field decodes four operating modes
// - Power-down keeps the converter code; here a power-down frame loads its data bits as the code
// - Host sends most significant bit first
// - Byte hosts hold select across bytes
module dac_serial_write_port (
    // Clock and reset
    input  wire logic                    sys_clk_in,
    input  wire logic                    sys_rst_in,
    // Link
    dac_link_if.dev                      link,
    // Converter code and mode
    output logic [15:0]                  code_out,
    output dac_link_pkg::pwr_mode_t      mode_out,
    output logic                         core_on_out,
    output logic                         out_hiz_out,
    output logic                         out_pd_100k_out,
    output logic                         out_pd_1k_out,
    // Frame events
    output logic                         frame_active_out,
    output logic                         frame_done_out,
    output logic                         frame_abort_out,
    output logic                         soft_reset_out
);

    typedef struct packed {
        logic [1:0]              sync_n_s;
        logic [1:0]              sclk_s;
        logic [1:0]              din_s;
        logic                    sync_n_d;
        logic                    sclk_d;
        logic                    active;
        logic [23:0]             shreg;
        logic [4:0]              cnt;
        logic                    swrst_armed;
        logic [15:0]             code;
        dac_link_pkg::pwr_mode_t mode;
        logic                    done_p;
        logic                    abort_p;
        logic                    swrst_p;
    } dev_state_t;

    localparam logic [4:0] LAST_BIT = 5'h17;
    localparam logic [4:0] TOP_BYTE = 5'h07;

    localparam dev_state_t RST_STATE = '{
        sync_n_s:    2'h3,
        sclk_s:      2'h0,
        din_s:       2'h0,
        sync_n_d:    1'h1,
        sclk_d:      1'h0,
        active:      1'h0,
        shreg:       24'h000000,
        cnt:         5'h00,
        swrst_armed: 1'h0,
        code:        dac_link_pkg::MIDSCALE_CODE,
        mode:        dac_link_pkg::MODE_NORMAL,
        done_p:      1'h0,
        abort_p:     1'h0,
        swrst_p:     1'h0
    };

    dev_state_t state;
    dev_state_t next_state;

    logic        sync_fall;
    logic        sync_rise;
    logic        sclk_fall;
    logic [23:0] frame;

    // Output stage selection, shared by all four pad controls
    function automatic logic is_mode(input dac_link_pkg::pwr_mode_t m,
                                     input dac_link_pkg::pwr_mode_t want);
        return m == want;
    endfunction : is_mode

    always_comb begin
        next_state = state;
        next_state.done_p = 1'h0;
        next_state.abort_p = 1'h0;
        next_state.swrst_p = 1'h0;

        // Two flip-flops on each pin before any decision is made
        next_state.sync_n_s = {state.sync_n_s[0], link.sync_n};
        next_state.sclk_s = {state.sclk_s[0], link.sclk};
        next_state.din_s = {state.din_s[0], link.din};
        next_state.sync_n_d = state.sync_n_s[1];
        next_state.sclk_d = state.sclk_s[1];

        sync_fall = state.sync_n_d & ~state.sync_n_s[1];
        sync_rise = ~state.sync_n_d & state.sync_n_s[1];
        sclk_fall = state.sclk_d & ~state.sclk_s[1];
        frame = {state.shreg[22:0], state.din_s[1]};

        if (sync_fall) begin
            // A fresh falling select always restarts cleanly
            next_state.active = 1'h1;
            next_state.shreg = 24'h000000;
            next_state.cnt = 5'h00;
            next_state.swrst_armed = 1'h0;
        end else if (sync_rise) begin
            if (state.active) begin
                next_state.abort_p = 1'h1;
                if (state.swrst_armed) begin
                    next_state.code = dac_link_pkg::MIDSCALE_CODE;
                    next_state.mode = dac_link_pkg::MODE_NORMAL;
                    next_state.swrst_p = 1'h1;
                end
            end
            next_state.active = 1'h0;
            next_state.shreg = 24'h000000;
            next_state.cnt = 5'h00;
            next_state.swrst_armed = 1'h0;
        end else if (state.active && sclk_fall) begin
            next_state.shreg = frame;
            next_state.cnt = state.cnt + 5'h01;
            // Reset is armed once the top byte is all ones; an early select rise then performs it
            if (state.cnt == TOP_BYTE && frame[7:0] == dac_link_pkg::SWRST_TOP) begin
                next_state.swrst_armed = 1'h1;
            end
            if (state.cnt == LAST_BIT) begin
                // Further edges are ignored until select falls again to open a new frame
                next_state.active = 1'h0;
                next_state.done_p = 1'h1;
                next_state.swrst_armed = 1'h0;
                if (frame == dac_link_pkg::SWRST_FRAME) begin
                    next_state.code = dac_link_pkg::MIDSCALE_CODE;
                    next_state.mode = dac_link_pkg::MODE_NORMAL;
                    next_state.swrst_p = 1'h1;
                end else begin
                    next_state.code = frame[dac_link_pkg::DATA_W-1:0];
                    next_state.mode = dac_link_pkg::pwr_mode_t'(
                        frame[dac_link_pkg::MODE_BIT_HI:dac_link_pkg::MODE_BIT_LO]);
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            state <= RST_STATE;
        end else begin
            state <= next_state;
        end
    end

    // No power-down mode clears the code, but a power-down frame loads its data bits as the code
    assign code_out = state.code;
    assign mode_out = state.mode;
    assign core_on_out = is_mode(state.mode, dac_link_pkg::MODE_NORMAL);
    assign out_hiz_out = is_mode(state.mode, dac_link_pkg::MODE_HIZ);
    assign out_pd_100k_out = is_mode(state.mode, dac_link_pkg::MODE_PD_100K);
    assign out_pd_1k_out = is_mode(state.mode, dac_link_pkg::MODE_PD_1K);
    assign frame_active_out = state.active;
    assign frame_done_out = state.done_p;
    assign frame_abort_out = state.abort_p;
    assign soft_reset_out = state.swrst_p;

endmodule : dac_serial_write_port

//--- rtl/dac_serial_host.sv
// Link controller: APB registers, a small frame buffer and the serialiser.
// Assumes an APB master on sys_clk_in; the link clock is made here.
module dac_serial_host #(
    parameter int DEPTH    = 2,
    parameter int HALF_CYC = dac_link_pkg::SCLK_HALF_CYC
) (
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        sys_rst_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Link
    dac_link_if.ctl          link
);

    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
        $error("DEPTH must be a power of two of at least 2");
    end
    if (HALF_CYC < dac_link_pkg::SCLK_HALF_CYC || HALF_CYC > 255) begin : g_bad_half
        $error("HALF_CYC outside the serial clock limit");
    end

    typedef enum logic [4:0] {
        H_IDLE  = 5'h01,
        H_GAP   = 5'h02,
        H_SETUP = 5'h04,
        H_HIGH  = 5'h08,
        H_LOW   = 5'h10
    } host_st_t;

    typedef struct packed {
        host_st_t                st;
        logic [7:0]              div;
        logic [7:0]              gap;
        logic [23:0]             shreg;
        logic [4:0]              bits;
        logic                    full_len;
        logic                    sync_n;
        logic                    sclk;
        logic                    din;
        logic [4:0]              ctrl_len;
        logic                    idle_low;
        logic [DEPTH-1:0][23:0]  mem;
        logic [PW:0]             wr;
        logic [PW:0]             rd;
        logic [31:0]             prdata;
    } host_state_t;

    localparam logic [7:0]  HALF_LAST = 8'(HALF_CYC - 1);
    localparam logic [7:0]  GAP_LAST  = 8'(dac_link_pkg::SYNC_HIGH_CYC - 1);
    localparam logic [PW:0] PTR_ONE   = (PW+1)'(1);
    localparam logic [PW:0] PTR_FULL  = (PW+1)'(DEPTH);

    host_state_t state;
    host_state_t next_state;

    logic        fifo_full;
    logic        fifo_empty;
    logic        tick;
    logic        acc;
    logic        push_sel;
    logic        mapped;
    logic [23:0] wr_word;

    // Lengths of 0 or above 24 mean a whole frame
    function automatic logic [4:0] eff_len(input logic [4:0] len);
        return (len == 5'h00 || len > 5'h18) ? 5'h18 : len;
    endfunction : eff_len

    always_comb begin
        next_state = state;
        fifo_full = (state.wr - state.rd) == PTR_FULL;
        fifo_empty = state.wr == state.rd;
        tick = state.div == HALF_LAST;
        acc = psel_in & penable_in;
        push_sel = paddr_in == dac_link_pkg::REG_FRAME || paddr_in == dac_link_pkg::REG_WORD;
        mapped = push_sel || paddr_in == dac_link_pkg::REG_CTRL
                 || paddr_in == dac_link_pkg::REG_STATUS;
        // Word writes force the top bits to zero for normal updates
        wr_word = (paddr_in == dac_link_pkg::REG_WORD)
                  ? {6'h00, pwdata_in[17:0]} : pwdata_in[23:0];

        // A full buffer stalls the APB write rather than dropping it
        pready_out = ~(pwrite_in & push_sel & fifo_full);
        pslverr_out = acc & ~mapped;
        prdata_out = state.prdata;

        if (psel_in && !penable_in) begin
            unique case (paddr_in)
                dac_link_pkg::REG_CTRL: begin
                    next_state.prdata = 32'(state.ctrl_len)
                        | (32'(state.idle_low) << dac_link_pkg::CTRL_IDLE_BIT);
                end
                dac_link_pkg::REG_STATUS: begin
                    next_state.prdata = 32'h00000000;
                    next_state.prdata[dac_link_pkg::STAT_BUSY] = state.st != H_IDLE;
                    next_state.prdata[dac_link_pkg::STAT_FULL] = fifo_full;
                    next_state.prdata[dac_link_pkg::STAT_EMPTY] = fifo_empty;
                    next_state.prdata[dac_link_pkg::STAT_SYNC] = state.sync_n;
                end
                default: begin
                    next_state.prdata = 32'h00000000;
                end
            endcase
        end
        if (acc && pwrite_in && pready_out && push_sel) begin
            next_state.mem[state.wr[PW-1:0]] = wr_word;
            next_state.wr = state.wr + PTR_ONE;
        end
        if (acc && pwrite_in && paddr_in == dac_link_pkg::REG_CTRL) begin
            next_state.ctrl_len = pwdata_in[4:0];
            next_state.idle_low = pwdata_in[dac_link_pkg::CTRL_IDLE_BIT];
        end

        next_state.div = tick ? 8'h00 : state.div + 8'h01;
        unique case (state.st)
            H_IDLE: begin
                next_state.div = 8'h00;
                if (!fifo_empty) begin
                    next_state.shreg = state.mem[state.rd[PW-1:0]];
                    next_state.bits = eff_len(state.ctrl_len);
                    next_state.full_len = eff_len(state.ctrl_len) == 5'h18;
                    next_state.rd = state.rd + PTR_ONE;
                    next_state.sync_n = 1'h1;
                    next_state.gap = 8'h00;
                    next_state.st = H_GAP;
                end
            end
            H_GAP: begin
                next_state.div = 8'h00;
                next_state.gap = state.gap + 8'h01;
                if (state.gap == GAP_LAST) begin
                    next_state.sync_n = 1'h0;
                    next_state.st = H_SETUP;
                end
            end
            H_SETUP, H_LOW: begin
                if (tick) begin
                    if (state.st == H_LOW && state.bits == 5'h00) begin
                        // Whole frames may leave select low to save current
                        next_state.sync_n = ~(state.idle_low & state.full_len);
                        next_state.st = H_IDLE;
                    end else begin
                        next_state.sclk = 1'h1;
                        next_state.din = state.shreg[23];
                        next_state.shreg = {state.shreg[22:0], 1'h0};
                        next_state.bits = state.bits - 5'h01;
                        next_state.st = H_HIGH;
                    end
                end
            end
            H_HIGH: begin
                if (tick) begin
                    next_state.sclk = 1'h0;
                    next_state.st = H_LOW;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            state.st <= H_IDLE;
            state.div <= 8'h00;
            state.gap <= 8'h00;
            state.shreg <= 24'h000000;
            state.bits <= 5'h00;
            state.full_len <= 1'h0;
            state.sync_n <= 1'h1;
            state.sclk <= 1'h0;
            state.din <= 1'h0;
            state.ctrl_len <= dac_link_pkg::CTRL_LEN_RST;
            state.idle_low <= dac_link_pkg::CTRL_IDLE_RST;
            state.mem <= '0;
            state.wr <= '0;
            state.rd <= '0;
            state.prdata <= 32'h00000000;
        end else begin
            state <= next_state;
        end
    end

    // Select stays low through the whole frame, never split per byte
    assign link.sync_n = state.sync_n;
    assign link.sclk = state.sclk;
    assign link.din = state.din;

endmodule : dac_serial_host

//--- verification/dac_link_asserts.sv
// Checker of the converter write link, placed beside the link interface.
// Assumes link pins stay at one level for at least three clock periods.
module dac_link_asserts (
    // Clock and reset
    input wire logic                    sys_clk_in,
    input wire logic                    sys_rst_in,
    // Link
    input wire logic                    sync_n,
    input wire logic                    sclk,
    input wire logic                    din,
    // Converter state and events
    input wire logic [15:0]             code_out,
    input wire dac_link_pkg::pwr_mode_t mode_out,
    input wire logic                    core_on_out,
    input wire logic                    out_hiz_out,
    input wire logic                    out_pd_100k_out,
    input wire logic                    out_pd_1k_out,
    input wire logic                    frame_done_out,
    input wire logic                    frame_abort_out,
    input wire logic                    soft_reset_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic        sclk_q;
    logic        sync_q;
    logic [4:0]  cnt;
    logic [23:0] sr;
    logic        ones8;
    logic        arm_q;
    wire         fall  = sclk_q & ~sclk & ~sync_n;
    wire         start = sync_q & ~sync_n;
    wire         armed = ones8 && cnt >= 5'h08;

    // Bit count and frame copy hold until the next frame opens, so late pulses see them
    always_ff @(posedge sys_clk_in) begin
        sclk_q <= sclk;
        sync_q <= sync_n;
        if (sync_n && !sync_q) begin
            arm_q <= armed;
        end
        if (sys_rst_in || start) begin
            cnt   <= 5'h00;
            sr    <= 24'h000000;
            ones8 <= 1'b1;
        end else if (fall && cnt < 5'h18) begin
            cnt   <= cnt + 5'h01;
            sr    <= {sr[22:0], din};
            ones8 <= ones8 & (din | (cnt >= 5'h08));
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);

    AST_SCLK_IDLE: assert property (sync_n |-> !sclk)
        else $error("serial clock high outside a frame");
    AST_SYNC_GAP: assert property ($fell(sync_n) |-> $past(sync_n, 2) && $past(sync_n, 3))
        else $error("select high too briefly before a frame");
    AST_DONE_24: assert property (fall && cnt == 5'h17 |-> ##[2:6] frame_done_out)
        else $error("no completion after last falling edge");
    AST_DONE_CAUSE: assert property (frame_done_out |-> cnt == 5'h18)
        else $error("completion without a full frame");
    AST_LOAD: assert property (frame_done_out && sr != 24'hFFFFFF |=>
        code_out == sr[15:0] && mode_out == sr[17:16])
        else $error("loaded code or mode differs from frame");
    AST_SWRST: assert property (soft_reset_out |=>
        code_out == dac_link_pkg::MIDSCALE_CODE && mode_out == dac_link_pkg::MODE_NORMAL)
        else $error("software reset left wrong state");
    AST_ABORT_WHEN: assert property ($rose(sync_n) && cnt != 5'h00 && cnt < 5'h18
        && !armed |-> ##[2:6] frame_abort_out)
        else $error("early select rise not reported");
    AST_ARMED_RESET: assert property ($rose(sync_n) && armed && cnt < 5'h18
        |-> ##[2:6] soft_reset_out)
        else $error("started software reset was dropped");
    AST_ABORT_KEEP: assert property (frame_abort_out && !arm_q |->
        $stable(code_out) && $stable(mode_out) ##1 $stable(code_out) && $stable(mode_out))
        else $error("aborted frame changed state");
    AST_DECODE: assert property (
        core_on_out == (mode_out == dac_link_pkg::MODE_NORMAL)
        && out_hiz_out == (mode_out == dac_link_pkg::MODE_HIZ)
        && out_pd_100k_out == (mode_out == dac_link_pkg::MODE_PD_100K)
        && out_pd_1k_out == (mode_out == dac_link_pkg::MODE_PD_1K))
        else $error("mode decode wrong");
    AST_POR: assert property (disable iff (1'b0) $fell(sys_rst_in) |->
        code_out == dac_link_pkg::MIDSCALE_CODE && mode_out == dac_link_pkg::MODE_NORMAL)
        else $error("reset state not midscale");
endmodule : dac_link_asserts

//--- verification/tb_top.sv
// Bench: APB drives the link controller, the converter port listens on the link.
// Assumes a 250 MHz clock; results are read at the converter port's outputs.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                    sys_clk_in = 1'b0;
    logic                    sys_rst_in = 1'b1;
    logic                    psel_in    = 1'b0;
    logic                    penable_in = 1'b0;
    logic                    pwrite_in  = 1'b0;
    logic [7:0]              paddr_in   = 8'h00;
    logic [31:0]             pwdata_in  = 32'h0;
    logic [31:0]             prdata_out;
    logic                    pready_out;
    logic                    pslverr_out;
    logic [15:0]             code_out;
    dac_link_pkg::pwr_mode_t mode_out;
    logic                    core_on_out;
    logic                    out_hiz_out;
    logic                    out_pd_100k_out;
    logic                    out_pd_1k_out;
    logic                    frame_active_out;
    logic                    frame_done_out;
    logic                    frame_abort_out;
    logic                    soft_reset_out;
    int                      bad_count;
    int                      total_checks;
    int                      ev_cnt;
    logic [31:0]             rd;
    logic                    er;
    logic                    idle_lo = 1'b0;
    logic [17:0]             exp_st;

    always #2 sys_clk_in = ~sys_clk_in;

    dac_link_if dac_link_if_i ();
    dac_serial_host #(.DEPTH(2), .HALF_CYC(5)) dac_serial_host_i (.sys_clk_in, .sys_rst_in,
        .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
        .pslverr_out, .link(dac_link_if_i));
    dac_serial_write_port dac_serial_write_port_i (.sys_clk_in, .sys_rst_in,
        .link(dac_link_if_i), .code_out, .mode_out, .core_on_out, .out_hiz_out,
        .out_pd_100k_out, .out_pd_1k_out, .frame_active_out, .frame_done_out,
        .frame_abort_out, .soft_reset_out);
    dac_link_asserts dac_link_asserts_i (.sys_clk_in, .sys_rst_in,
        .sync_n(dac_link_if_i.sync_n), .sclk(dac_link_if_i.sclk), .din(dac_link_if_i.din),
        .code_out, .mode_out, .core_on_out, .out_hiz_out, .out_pd_100k_out, .out_pd_1k_out,
        .frame_done_out, .frame_abort_out, .soft_reset_out);

    // Any end of frame, good or not, counts as one event
    always @(posedge sys_clk_in) begin
        if (frame_done_out === 1'b1 || frame_abort_out === 1'b1 || soft_reset_out === 1'b1)
            ev_cnt <= ev_cnt + 1;
    end

    // Converter state after a frame of the given length
    function automatic logic [17:0] model(input logic [17:0] cur, input logic [23:0] f,
                                          input int len);
        if (len >= 8 && f[23:16] == 8'hFF)
            return {2'h0, dac_link_pkg::MIDSCALE_CODE};
        if (len < 24)
            return cur;
        return f[17:0];
    endfunction : model

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_dev();
        // A frame is never left open once its end has been reported
        chk({13'h0, frame_active_out, mode_out, code_out}, {14'h0, exp_st});
    endtask : chk_dev

    // Ready, read data and error are taken at the very edge that completes the access
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge sys_clk_in);
        penable_in <= 1'b1;
        for (n = 0; n < 3000; n++) begin
            @(posedge sys_clk_in);
            if (pready_out === 1'b1)
                break;
        end
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        if (n == 3000) begin
            bad_count++;
            summarize();
        end
        @(posedge sys_clk_in);
    endtask : apb

    task automatic wait_ev(input int target);
        int n;
        for (n = 0; n < 3000 && ev_cnt < target; n++)
            @(posedge sys_clk_in);
        if (n == 3000) begin
            bad_count++;
            summarize();
        end
        repeat (8) @(posedge sys_clk_in);
    endtask : wait_ev

    task automatic send(input logic [23:0] f, input int len);
        int b;
        apb(1'b1, dac_link_pkg::REG_CTRL, {23'h0, idle_lo, 3'h0, 5'(len)});
        b = ev_cnt;
        apb(1'b1, dac_link_pkg::REG_FRAME, {8'h00, f});
        wait_ev(b + 1);
        exp_st = model(exp_st, f, len);
        chk_dev();
    endtask : send

    initial begin
        logic [23:0] f;
        int          i;
        int          b;
        void'($urandom(32'h77BDAB94));
        exp_st = {2'h0, dac_link_pkg::MIDSCALE_CODE};
        repeat (20) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        @(posedge sys_clk_in);
        chk_dev();
        apb(1'b0, dac_link_pkg::REG_STATUS, 32'h0);
        chk(rd, 32'h0000000C);
        apb(1'b0, dac_link_pkg::REG_CTRL, 32'h0);
        chk(rd, 32'h00000018);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, er}, 32'h00000001);
        // Every mode, then its one-hot decode
        for (i = 0; i < 4; i++) begin
            send({6'h00, i[1:0], 16'($urandom)}, 24);
            chk({28'h0, core_on_out, out_hiz_out, out_pd_100k_out, out_pd_1k_out},
                32'h8 >> i);
        end
        for (i = 0; i < 6; i++)
            send({6'h00, 18'($urandom)}, 24);
        send({6'h00, 18'($urandom)}, 23);
        send({6'h00, 18'($urandom)}, $urandom_range(22, 1));
        send(24'hFFFFFF, 7);
        send(24'hFFFFFF, 8);
        send({6'h00, 18'($urandom)}, 24);
        send(24'hFFFFFF, 24);
        // Four words against a two-entry buffer: the last write stalls
        b = ev_cnt;
        for (i = 0; i < 4; i++) begin
            f = {6'h00, 18'($urandom)};
            apb(1'b1, dac_link_pkg::REG_WORD, {8'h00, f});
            exp_st = f[17:0];
        end
        apb(1'b0, dac_link_pkg::REG_STATUS, 32'h0);
        chk({29'h0, rd[2:0]}, 32'h00000003);
        wait_ev(b + 4);
        chk_dev();
        idle_lo = 1'b1;
        send({6'h00, 18'($urandom)}, 24);
        apb(1'b0, dac_link_pkg::REG_STATUS, 32'h0);
        chk({31'h0, rd[3]}, 32'h0);
        send({6'h00, 18'($urandom)}, 24);
        idle_lo = 1'b0;
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        @(posedge sys_clk_in);
        exp_st = {2'h0, dac_link_pkg::MIDSCALE_CODE};
        chk_dev();
        summarize();
    end
endmodule : tb_top
